// file: rtl/fci_pkg.sv
// Constants for the flash command and status interface.
// Assumes a 32-bit plain register port and a separate array engine.
package fci_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] FCI_OFS_CONTROL = 8'h00;
	localparam logic [7:0] FCI_OFS_COMMAND = 8'h04;
	localparam logic [7:0] FCI_OFS_STATUS = 8'h08;
	localparam logic [31:0] FCI_RST_WORD = 32'h00000000;

	// ==========================================
	// Control fields
	localparam int FCI_CTL_RDY = 0;
	localparam int FCI_CTL_LOCK = 2;
	localparam int FCI_CTL_CMD = 3;
	localparam int FCI_CTL_WS = 6;

	// ==========================================
	// Command fields
	localparam logic [7:0] FCI_KEY = 8'hA5;
	localparam int FCI_KEY_LSB = 24;
	localparam int FCI_PAGE_LSB = 8;
	localparam int FCI_PAGE_W = 16;
	localparam int FCI_PAGE_VALID = 10;
	localparam logic [15:0] FCI_PAGE_MASK = 16'h03FF;

	// ==========================================
	// Status fields
	localparam int FCI_ST_RDY = 0;
	localparam int FCI_ST_LOCK = 2;
	localparam int FCI_ST_CMD = 3;
	localparam int FCI_ST_SEC = 4;
	localparam int FCI_ST_QPR = 5;
	localparam int FCI_ST_SZ_LSB = 13;
	localparam int FCI_ST_LK_LSB = 16;
	localparam logic [2:0] FCI_SIZE_CODE = 3'h5;

	// ==========================================
	// Fuse layout used for security checks
	localparam int FCI_FUSE_EPFL = 16;
	localparam int FCI_FUSE_BP_HI = 19;
	localparam logic [2:0] FCI_FUSE_BYTE_PROT = 3'h2;
	localparam int FCI_REGION_SHIFT = 6;

	typedef enum logic [3:0] {
		FCI_CMD_NOP = 4'h0,
		FCI_CMD_WRITE_PAGE = 4'h1,
		FCI_CMD_ERASE_PAGE = 4'h2,
		FCI_CMD_CLEAR_PAGE_BUFFER = 4'h3,
		FCI_CMD_LOCK_REGION = 4'h4,
		FCI_CMD_UNLOCK_REGION = 4'h5,
		FCI_CMD_ERASE_ALL = 4'h6,
		FCI_CMD_FUSE_BIT_WRITE = 4'h7,
		FCI_CMD_FUSE_BIT_ERASE = 4'h8,
		FCI_CMD_SET_SECURITY = 4'h9,
		FCI_CMD_FUSE_BYTE_PROGRAM = 4'hA,
		FCI_CMD_FUSE_ERASE_ALL = 4'hB,
		FCI_CMD_QUICK_PAGE_CHECK = 4'hC,
		FCI_CMD_USER_PAGE_WRITE = 4'hD,
		FCI_CMD_USER_PAGE_ERASE = 4'hE,
		FCI_CMD_USER_PAGE_CHECK = 4'hF
	} fci_cmd_type;

	typedef enum logic [1:0] {
		FCI_ST_IDLE = 2'b00,
		FCI_ST_BUSY = 2'b01
	} fci_state_type;

endpackage

// file: rtl/fci_flash_command_status_interface.sv
// Control, command and status registers of the embedded flash controller.
// Assumes an array engine that takes a start pulse and answers with done.
`timescale 1ns/1ns
module fci_flash_command_status_interface
	import fci_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Page buffer write observation
	input wire logic pbuf_write,
	input wire logic [15:0] pbuf_page,
	// Array engine
	output logic cmd_start,
	output logic [3:0] cmd_code,
	output logic [15:0] cmd_page,
	input wire logic cmd_done,
	input wire logic quick_read_in,
	input wire logic [31:0] fuse_state,
	input wire logic security_in,
	// Array read timing and interrupt
	output logic read_wait_states,
	output logic irq
);

	// ==========================================
	// Registers
	logic [31:0] ctl_q;
	logic [15:0] page_number_q;
	logic [3:0] cmd_q;
	logic lock_fault_q;
	logic cmd_fault_q;
	logic quick_read_result_q;
	fci_state_type state_q;
	logic ready_flag;
	logic cmd_wr;
	logic key_ok;
	logic code_bad;
	logic locked_hit;
	logic sec_refuse;
	logic accept;
	logic [3:0] new_code;
	logic [15:0] new_page;
	logic [3:0] region;
	logic st_read;
	logic ctl_wr;
	// Command decode and refusal reasons
	logic attr_engine;
	logic attr_page_lock;
	logic attr_all_lock;
	logic attr_fuse_bit;
	logic attr_fuse_byte;
	logic attr_fuse_all;
	logic busy_is_check;
	logic refuse_busy;
	logic refuse_key;
	logic refuse_code;
	logic refuse_lock;
	// Region lock flags and read views
	logic [15:0] region_lock_flag;
	logic [31:0] ctl_view;
	logic [31:0] cmd_view;
	logic [31:0] st_view;
	logic [31:0] rd_mux;

	assign ready_flag = (state_q == FCI_ST_IDLE);
	assign cmd_wr = reg_write && (reg_addr == FCI_OFS_COMMAND);
	assign ctl_wr = reg_write && (reg_addr == FCI_OFS_CONTROL);
	assign st_read = reg_read && (reg_addr == FCI_OFS_STATUS);
	assign new_code = reg_wdata[3:0];
	assign new_page = reg_wdata[FCI_PAGE_LSB +: FCI_PAGE_W] & FCI_PAGE_MASK;
	assign key_ok = (reg_wdata[FCI_KEY_LSB +: 8] == FCI_KEY);
	// Upper code bits 7:4 are unused codes
	assign code_bad = (reg_wdata[7:4] != 4'h0);
	assign region = new_page[FCI_PAGE_VALID-1 -: 4];

	// ==========================================
	// Command decode
	// Every code is listed, so no code slips past the checks unseen
	always_comb
	begin
		attr_engine = 1'b0;
		attr_page_lock = 1'b0;
		attr_all_lock = 1'b0;
		attr_fuse_bit = 1'b0;
		attr_fuse_byte = 1'b0;
		attr_fuse_all = 1'b0;
		case (new_code)
			FCI_CMD_NOP:
			begin
				attr_engine = 1'b0;
			end
			FCI_CMD_WRITE_PAGE:
			begin
				attr_engine = 1'b1;
				attr_page_lock = 1'b1;
			end
			FCI_CMD_ERASE_PAGE:
			begin
				attr_engine = 1'b1;
				attr_page_lock = 1'b1;
			end
			FCI_CMD_CLEAR_PAGE_BUFFER:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_LOCK_REGION:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_UNLOCK_REGION:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_ERASE_ALL:
			begin
				attr_engine = 1'b1;
				attr_all_lock = 1'b1;
			end
			FCI_CMD_FUSE_BIT_WRITE:
			begin
				attr_engine = 1'b1;
				attr_fuse_bit = 1'b1;
			end
			FCI_CMD_FUSE_BIT_ERASE:
			begin
				attr_engine = 1'b1;
				attr_fuse_bit = 1'b1;
			end
			FCI_CMD_SET_SECURITY:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_FUSE_BYTE_PROGRAM:
			begin
				attr_engine = 1'b1;
				attr_fuse_byte = 1'b1;
			end
			FCI_CMD_FUSE_ERASE_ALL:
			begin
				attr_engine = 1'b1;
				attr_fuse_all = 1'b1;
			end
			FCI_CMD_QUICK_PAGE_CHECK:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_USER_PAGE_WRITE:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_USER_PAGE_ERASE:
			begin
				attr_engine = 1'b1;
			end
			FCI_CMD_USER_PAGE_CHECK:
			begin
				attr_engine = 1'b1;
			end
			default:
				attr_engine = 1'b0;
		endcase
	end

	// ==========================================
	// Region lock flags
	// A programmed lock fuse (0) marks its region locked
	genvar gi;
	generate
		for (gi = 0; gi < $bits(region_lock_flag); gi = gi + 1)
		begin : g_region
			assign region_lock_flag[gi] = ~fuse_state[gi];
		end
	endgenerate

	// Flags come straight from fuses, so no shadow copy can go stale
	always_comb
	begin
		locked_hit = 1'b0;
		if (attr_page_lock)
			locked_hit = region_lock_flag[region];
		else if (attr_all_lock)
			locked_hit = |region_lock_flag;
	end

	// Protected fuse commands while the chip is secured
	always_comb
	begin
		sec_refuse = 1'b0;
		if (security_in)
		begin
			if (attr_fuse_bit)
				sec_refuse = new_page >= 16'(FCI_FUSE_EPFL) &&
					new_page <= 16'(FCI_FUSE_BP_HI);
			else if (attr_fuse_byte)
				sec_refuse = new_page[2:0] == FCI_FUSE_BYTE_PROT;
			else if (attr_fuse_all)
				sec_refuse = 1'b1;
		end
	end

	// ==========================================
	// Refusal reasons; lock checks only count for a clean write
	assign refuse_busy = cmd_wr && !ready_flag;
	assign refuse_key = cmd_wr && !key_ok;
	assign refuse_code = cmd_wr && code_bad;
	assign refuse_lock = cmd_wr && ready_flag && key_ok && !code_bad &&
		(locked_hit || sec_refuse);
	assign accept = cmd_wr && !refuse_busy && !refuse_key && !refuse_code
		&& !refuse_lock;

	// ==========================================
	// Control register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ctl_q <= FCI_RST_WORD;
		else if (ctl_wr)
			ctl_q <= reg_wdata;
	end
	assign read_wait_states = ctl_q[FCI_CTL_WS];

	// ==========================================
	// Command register and page number
	// An accepted command write wins over a page buffer write in one cycle
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			page_number_q <= 16'h0000;
		else if (accept)
			page_number_q <= new_page;
		else if (pbuf_write)
			page_number_q <= pbuf_page & FCI_PAGE_MASK;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cmd_q <= 4'h0;
		else if (accept)
			cmd_q <= new_code;
	end

	// ==========================================
	// Sequencer
	// A no-operation is taken but never makes the block busy
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			state_q <= FCI_ST_IDLE;
		else
			case (state_q)
				FCI_ST_IDLE:
					if (accept && attr_engine)
						state_q <= FCI_ST_BUSY;
				FCI_ST_BUSY:
					if (cmd_done)
						state_q <= FCI_ST_IDLE;
				default:
					state_q <= FCI_ST_IDLE;
			endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cmd_start <= 1'b0;
		else
			cmd_start <= accept && attr_engine;
	end
	assign cmd_code = cmd_q;
	assign cmd_page = page_number_q;

	// Result latched when a quick page check or user page check finishes
	assign busy_is_check = cmd_q == FCI_CMD_QUICK_PAGE_CHECK ||
		cmd_q == FCI_CMD_USER_PAGE_CHECK;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			quick_read_result_q <= 1'b0;
		else if (state_q == FCI_ST_BUSY && cmd_done && busy_is_check)
			quick_read_result_q <= quick_read_in;
	end

	// ==========================================
	// Fault flags: a new fault wins over the read clear
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cmd_fault_q <= 1'b0;
		else if (refuse_busy || refuse_key || refuse_code)
			cmd_fault_q <= 1'b1;
		else if (st_read)
			cmd_fault_q <= 1'b0;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			lock_fault_q <= 1'b0;
		else if (refuse_lock)
			lock_fault_q <= 1'b1;
		else if (st_read)
			lock_fault_q <= 1'b0;
	end

	// ==========================================
	// Read views of the three registers
	assign ctl_view = ctl_q & 32'h0000004D;
	assign cmd_view = {8'h00, page_number_q, 4'h0, cmd_q};
	assign st_view = {region_lock_flag, FCI_SIZE_CODE, 7'h00,
		quick_read_result_q, security_in, cmd_fault_q,
		lock_fault_q, 1'b0, ready_flag};

	// ==========================================
	// Read data, one cycle after the strobe
	// Unmapped offsets return zero rather than a stale word
	always_comb
	begin
		rd_mux = FCI_RST_WORD;
		case (reg_addr)
			FCI_OFS_CONTROL:
				rd_mux = ctl_view;
			FCI_OFS_COMMAND:
				rd_mux = cmd_view;
			FCI_OFS_STATUS:
				rd_mux = st_view;
			default:
				rd_mux = FCI_RST_WORD;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= FCI_RST_WORD;
		else if (reg_read)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= FCI_RST_WORD;
	end

	// ==========================================
	// Interrupt
	// Ready is a level, so its interrupt stays high while idle
	assign irq = (ctl_q[FCI_CTL_RDY] && ready_flag) ||
		(ctl_q[FCI_CTL_LOCK] && lock_fault_q) ||
		(ctl_q[FCI_CTL_CMD] && cmd_fault_q);

endmodule

// file: test/fci_engine_model.sv
// Behavioural flash array engine on the far side of the block.
// Assumes cmd_start is a one-cycle pulse.
`timescale 1ns/1ns
module fci_engine_model #(
	parameter int LAT = 6
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cmd_start,
	input wire logic [3:0] cmd_code,
	output logic cmd_done,
	output logic quick_read_in
);
	int cnt;
	logic res;
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cnt <= 0;
		else if (cmd_start)
			cnt <= LAT;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (cmd_start)
			res <= ~cmd_code[0];
	end
	assign cmd_done = cnt == 1;
	// Result only means something with done
	assign quick_read_in = cmd_done ? res : cnt[0];
endmodule

// file: test/fci_chk.sv
// Port assertions for the flash command and status block.
// Assumes one clock domain; bound from the bench top.
`timescale 1ns/1ns
module fci_chk
	import fci_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic cmd_start,
	input wire logic [3:0] cmd_code,
	input wire logic [15:0] cmd_page,
	input wire logic cmd_done,
	input wire logic [31:0] fuse_state,
	input wire logic security_in,
	input wire logic read_wait_states,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_key_wr;
		reg_write && reg_addr == FCI_OFS_COMMAND && reg_wdata[31:24] == FCI_KEY;
	endsequence
	sequence s_st_rd;
		reg_read && reg_addr == FCI_OFS_STATUS;
	endsequence
	a_key_zero:
	assert property (reg_read && reg_addr == FCI_OFS_COMMAND
		|=> reg_rdata[31:24] == 8'h00) else $error("key reads back");
	a_start_key:
	assert property (cmd_start |-> $past(reg_write && reg_wdata[31:24] ==
		FCI_KEY)) else $error("start without key");
	a_start_fields:
	assert property (s_key_wr ##1 cmd_start |-> cmd_code == $past(reg_wdata
		[3:0]) && cmd_page == ($past(reg_wdata[23:8]) & FCI_PAGE_MASK))
		else $error("start fields wrong");
	a_busy_drop:
	assert property (cmd_start |=> !cmd_start throughout (##[0:40] cmd_done))
		else $error("restart while busy");
	a_busy_flag:
	assert property (cmd_start ##1 s_st_rd |=> !reg_rdata[FCI_ST_RDY])
		else $error("ready while busy");
	a_wait_state:
	assert property (reg_write && reg_addr == FCI_OFS_CONTROL |=>
		read_wait_states == $past(reg_wdata[FCI_CTL_WS])) else $error("ws");
	a_irq_off:
	assert property (reg_write && reg_addr == FCI_OFS_CONTROL &&
		(reg_wdata & 32'h0000000D) == 0 |=> !irq) else $error("irq masked");
	a_size_code:
	assert property (s_st_rd |=> reg_rdata[15:13] == FCI_SIZE_CODE)
		else $error("size code");
	a_lock_flags:
	assert property (s_st_rd |=> reg_rdata[31:16] == ~$past(fuse_state[15:0]))
		else $error("lock flags");
	a_sec_state:
	assert property (s_st_rd |=> reg_rdata[FCI_ST_SEC] == $past(security_in))
		else $error("security bit");
endmodule

// file: test/fci_flash_command_status_interface_tb_top.sv
// Self-checking bench for the flash command and status block.
// Assumes the engine model and checker are compiled first.
`timescale 1ns/1ns
module fci_flash_command_status_interface_tb_top;
	import fci_pkg::*;
	localparam int LAT = 6;
	logic mclk = 0, nrst = 0, reg_write = 0, reg_read = 0, pbuf_write = 0;
	logic security_in = 0, cmd_start, cmd_done, quick_read_in, irq;
	logic read_wait_states, lk = 0, cf = 0, qp = 0;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, fuse_state = 32'hFFFFFFFF, d, cv, v;
	logic [15:0] pbuf_page = 0, cmd_page;
	logic [3:0] cmd_code;
	int n_errors = 0, n_tests = 0, seed = 31, cyc = 0;
	fci_flash_command_status_interface fci_flash_command_status_interface_inst (.*);
	fci_engine_model #(.LAT(LAT)) fci_engine_model_inst (.*);
	initial forever #25 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			conclude();
		end
	end
	// ==========
	// Tasks
	task automatic conclude();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] w);
		@(posedge mclk);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge mclk);
		reg_write <= 0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge mclk);
		reg_read <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	function automatic logic [31:0] st();
		return {~fuse_state[15:0], FCI_SIZE_CODE, 7'h00, qp, security_in, cf,
			lk, 2'b01};
	endfunction
	task automatic issue(logic [31:0] w);
		logic [3:0] c;
		logic [9:0] p;
		c = w[3:0];
		p = w[17:8];
		cf = w[31:24] != FCI_KEY || w[7:4] != 0;
		lk = !cf && (c inside {1, 2} && !fuse_state[p[9:6]] ||
			c == 6 && !(&fuse_state[15:0]) || security_in &&
			(c inside {7, 8} && p inside {[16:19]} ||
			c == 10 && p[2:0] == 2 || c == 11));
		if (!cf && !lk && c inside {12, 15})
			qp = c == 12;
		wr(FCI_OFS_COMMAND, w);
		repeat (LAT + 3) @(posedge mclk);
		@(negedge mclk);
	endtask
	// ==========
	// Main sequence
	initial
	begin
		repeat (8) @(posedge mclk);
		nrst <= 1;
		rd(FCI_OFS_CONTROL);
		chk(d, FCI_RST_WORD);
		rd(FCI_OFS_STATUS);
		chk(d, st());
		// First sixteen passes walk every code against a locked region
		for (int i = 0; i < 56; i++)
		begin
			fuse_state <= i < 16 ? 32'hFFFFFFFE : $random(seed);
			security_in <= i < 16 ? 1'b1 : 1'($random(seed));
			cv = $random(seed);
			wr(FCI_OFS_CONTROL, cv);
			rd(FCI_OFS_CONTROL);
			chk(d, cv & 32'h4D);
			v = $random(seed);
			if (v[30])
				v[31:24] = FCI_KEY;
			if (v[29])
				v[7:4] = 4'h0;
			issue(i < 16 ? {FCI_KEY, 20'h00120, 4'(i)} : v);
			chk(irq, cv[0] | lk & cv[2] | cf & cv[3]);
			rd(FCI_OFS_STATUS);
			chk(d, st());
			lk = 0;
			cf = 0;
			rd(FCI_OFS_STATUS);
			chk(d, st());
		end
		fuse_state <= 32'hFFFFFFFF;
		wr(FCI_OFS_COMMAND, 32'hA5015501);
		rd(FCI_OFS_STATUS);
		chk(d[0], 0);
		wr(FCI_OFS_COMMAND, 32'hA5020302);
		repeat (LAT + 3) @(posedge mclk);
		rd(FCI_OFS_COMMAND);
		chk(d >> 8, 32'h155);
		cf = 1;
		rd(FCI_OFS_STATUS);
		chk(d, st());
		cf = 0;
		@(posedge mclk);
		pbuf_write <= 1;
		pbuf_page <= 16'hFE77;
		@(posedge mclk);
		pbuf_write <= 0;
		rd(FCI_OFS_COMMAND);
		chk(d >> 8, 32'h277);
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20);
		chk(d, 0);
		rd(FCI_OFS_CONTROL);
		chk(d, cv & 32'h4D);
		conclude();
	end
endmodule
bind fci_flash_command_status_interface fci_chk fci_chk_inst (.*);
